// ===== core/sao_pkg.sv
/*
 * Shared constants and types for the serial accumulator operations block.
 * Assumes one 20 MHz clock where one clock is one bit time of the word cycle.
 */
package sao_pkg;
    // Opcodes, instruction bits 3..8
    localparam logic [5:0] OPC_AND = 6'h0C;
    localparam logic [5:0] OPC_OR = 6'h0E;
    localparam logic [5:0] OPC_XOR = 6'h0F;
    localparam logic [5:0] OPC_XCHG = 6'h26;
    localparam logic [5:0] OPC_RSH = 6'h36;
    localparam logic [5:0] OPC_LSH = 6'h37;
    // Bit times: T24, T23 down to T0, then the final pulse time
    localparam logic [4:0] BT_T24 = 5'h18;
    localparam logic [4:0] BT_T23 = 5'h17;
    localparam logic [4:0] BT_T16 = 5'h10;
    localparam logic [4:0] BT_T15 = 5'h0F;
    localparam logic [4:0] BT_T10 = 5'h0A;
    localparam logic [4:0] BT_T9 = 5'h09;
    localparam logic [4:0] BT_T8 = 5'h08;
    localparam logic [4:0] BT_T0 = 5'h00;
    localparam logic [4:0] BT_TP = 5'h19;
    localparam real CLOCK_NS = 50.0;
    // Register byte offsets
    localparam logic [7:0] A_INSTR = 8'h00;
    localparam logic [7:0] A_MEM = 8'h04;
    localparam logic [7:0] A_ACC = 8'h08;
    localparam logic [7:0] A_EXT = 8'h0C;
    localparam logic [7:0] A_IDX = 8'h10;
    localparam logic [7:0] A_PC = 8'h14;
    localparam logic [7:0] A_STATUS = 8'h18;
    localparam logic [7:0] A_CTRL = 8'h1C;
    localparam logic [7:0] A_ADDR = 8'h20;
    localparam logic [2:0] WORD_SIZE = 3'h2;
    // Reset values
    localparam logic [0:23] RST_WORD = 24'h000000;
    localparam logic [10:23] RST_PC = 14'h0000;
    // Field positions
    localparam int F_INDEX_TAG = 0;
    localparam int F_FILL = 9;
    localparam int F_CYCLE = 10;

    typedef enum logic [2:0] {
        PH_FETCH = 3'b000,
        PH_EXEC = 3'b001,
        PH_XFER = 3'b010,
        PH_COUNT = 3'b011,
        PH_NEXT = 3'b100
    } sao_phase_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } sao_ahb_req_s;
endpackage : sao_pkg

// ===== core/sao_serial_acc.sv
/*
 * Bit-serial accumulator unit: logical ops, register change, shifts.
 * Assumes an AHB-Lite master, word transfers only, and that the operand
 * register holds the current instruction; bit 0 is the MSB of a word.
 */
// What this block does
// [RQ1] Opcode 14 ANDs operand into accumulator serially
// [RQ2] Opcode 16 ORs operand into accumulator serially
// [RQ3] Opcode 17 XORs operand into accumulator serially
// [RQ4] Logical execute returns to fetch at final pulse
// [RQ5] Opcode 46: one pulse fetch, then transfer
// [RQ6] Bits 20,16,23,14 reload accumulator in transfer
// [RQ7] Complement flag: set after one, clear T0
// [RQ8] Bit 17 stops exchange after nine bits
// [RQ9] Short index load sets flag, extends bit 15
// [RQ10] Shift indexing only T23 to T16
// [RQ11] Opcode 66 bit 10 selects cycle or shift
// [RQ12] Carry held off while index flag clear
// [RQ13] After T15 adder passes operand bit through
// [RQ14] Clear address T10, load and count T9
// [RQ15] No memory pulse at T8 while counting
// [RQ16] Right shift moves two places via holds
// [RQ17] Top fill: sign, extension, or zero
// [RQ18] Five-bit down-counter, held during multiply
// [RQ19] Zero even count sets skip at T0
// [RQ20] Zero odd count adds one single shift
// [RQ21] Next phase: increment, T9 transfer, refetch
// [RQ22] Opcode 67 left modes, count phase at T9
// [RQ23] Transfer bits feed extension and index registers
`timescale 1ns/1ps
module sao_serial_acc (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Memory timing
    output logic mem_pulse
);
    sao_pkg::sao_phase_e ph_ff, nxt_ph;
    sao_pkg::sao_ahb_req_s req_ff, nxt_req;
    logic [4:0] bt_ff;
    logic [0:23] acc_ff, ext_ff, idx_ff, op_ff, mem_ff;
    logic [0:23] nxt_acc, nxt_ext, nxt_idx, nxt_op;
    logic [9:23] addr_ff, nxt_addr, ld;
    logic [10:23] pc_ff;
    logic [31:0] hrdata_ff, rd_data;
    logic run_ff, pend_ff, seen_ff, ix_ff, carry_ff, shmode_ff, fill_ff;
    logic single_ff, skip_ff, inc_ff, active_ff, mhold_ff, mem_pulse_ff;
    logic ah1_ff, ah2_ff, eh1_ff, eh2_ff;
    logic [5:0] opc_ff;

    function automatic logic at(input logic [4:0] bt, input logic [4:0] t);
        return bt == t;
    endfunction : at

    function automatic logic wr_hit(input sao_pkg::sao_ahb_req_s r,
                                    input logic [7:0] off);
        return r.valid && r.write && r.addr == off;
    endfunction : wr_hit

    // Decoding
    // The operand rotates in fetch and holds data in execute, so the opcode
    // is latched at the fetch cycle's first bit time and decoded from there
    wire logic [5:0] opc = (ph_ff == sao_pkg::PH_FETCH && bt_ff == sao_pkg::BT_T24)
        ? op_ff[3:8] : opc_ff;
    wire logic dbt = bt_ff <= sao_pkg::BT_T23;
    wire logic tp = at(bt_ff, sao_pkg::BT_TP);
    wire logic t24 = at(bt_ff, sao_pkg::BT_T24);
    wire logic t0 = at(bt_ff, sao_pkg::BT_T0);
    wire logic is_and = opc == sao_pkg::OPC_AND;
    wire logic is_or = opc == sao_pkg::OPC_OR;
    wire logic is_xor = opc == sao_pkg::OPC_XOR;
    wire logic is_logic = is_and || is_or || is_xor;
    wire logic is_xchg = opc == sao_pkg::OPC_XCHG;
    wire logic is_rsh = opc == sao_pkg::OPC_RSH;
    wire logic is_lsh = opc == sao_pkg::OPC_LSH;
    wire logic is_shift = is_rsh || is_lsh;
    wire logic ph_fetch = ph_ff == sao_pkg::PH_FETCH;
    wire logic ph_xfer = ph_ff == sao_pkg::PH_XFER;
    wire logic ph_count = ph_ff == sao_pkg::PH_COUNT;
    wire logic ph_next = ph_ff == sao_pkg::PH_NEXT;
    wire logic fetch_run = ph_fetch && run_ff;
    wire logic idle = ph_fetch && !run_ff && !pend_ff;
    wire logic start = ph_fetch && !run_ff && pend_ff && tp;
    wire logic [4:0] cnt = addr_ff[9:13];
    wire logic odd = addr_ff[14];
    wire logic cnt_zero = cnt == 5'h00;

    // Serial index adder of the fetch phase
    wire logic ab = acc_ff[23];
    wire logic eb = ext_ff[23];
    wire logic xb = idx_ff[23];
    wire logic cb = op_ff[23];
    wire logic xadd = xb && ix_ff;
    // A carry left over from the last indexed bit must not reach the modifiers
    wire logic cin = carry_ff && ix_ff; // RQ12
    wire logic sum = cb ^ xadd ^ cin;
    wire logic cout = (cb && xadd) || (cb && cin) || (xadd && cin);
    wire logic lres = (is_and && ab && cb) || (is_or && (ab || cb)) || (is_xor && (ab ^ cb));

    // Register change controls are the instruction's own static bits
    wire logic a_keep = !(op_ff[20] || op_ff[16] || op_ff[14] || op_ff[23]);
    wire logic e_keep = !(op_ff[22] || op_ff[21] || op_ff[18]);
    wire logic x_keep = !(op_ff[15] || op_ff[19]);
    wire logic a_new = (a_keep && ab) || (op_ff[20] && eb) || (op_ff[16] && xb)
        || (op_ff[14] && (ab ^ seen_ff)); // RQ6 RQ7
    wire logic e_new = (e_keep && eb) || (op_ff[21] && ab) || (op_ff[18] && xb); // RQ23
    wire logic x_new = ix_ff ? idx_ff[0] // RQ9
        : (x_keep && xb) || (op_ff[19] && eb) || (op_ff[15] && ab); // RQ23
    wire logic short_xchg = ph_xfer && at(bt_ff, sao_pkg::BT_T15) && op_ff[17];

    // Shift data paths
    wire logic [0:1] fill2 = fill_ff ? 2'b00 : shmode_ff ? {eh1_ff, eh2_ff}
        : {acc_ff[0], acc_ff[0]}; // RQ17
    wire logic fill1 = !fill_ff && (shmode_ff ? eh2_ff : acc_ff[0]); // RQ17
    wire logic [0:1] lfill = shmode_ff ? acc_ff[0:1] : 2'b00;

    // Address load image: bits 10..23 sit rotated in the operand at T9
    always_comb begin
        ld = '0;
        ld[9] = sum;
        for (int k = 10; k <= 23; k++) begin
            ld[k] = op_ff[k - 10];
        end
    end

    // Bus request and read data
    assign nxt_req = '{valid: hsel && hready && htrans[1] && hsize == sao_pkg::WORD_SIZE,
                       write: hwrite, addr: haddr[7:0]};

    always_comb begin
        unique case (haddr[7:0])
            sao_pkg::A_INSTR: rd_data = {8'h00, op_ff};
            sao_pkg::A_MEM: rd_data = {8'h00, mem_ff};
            sao_pkg::A_ACC: rd_data = {8'h00, acc_ff};
            sao_pkg::A_EXT: rd_data = {8'h00, ext_ff};
            sao_pkg::A_IDX: rd_data = {8'h00, idx_ff};
            sao_pkg::A_PC: rd_data = {18'h00000, pc_ff};
            sao_pkg::A_STATUS: rd_data = {17'h00000, addr_ff[9:14], fill_ff, shmode_ff,
                ix_ff, single_ff, skip_ff, run_ff || pend_ff, ph_ff};
            sao_pkg::A_CTRL: rd_data = {31'h00000000, mhold_ff};
            sao_pkg::A_ADDR: rd_data = {17'h00000, addr_ff};
            default: rd_data = 32'h00000000;
        endcase
    end

    // Phase counter
    always_comb begin
        nxt_ph = ph_ff;
        unique case (ph_ff)
            sao_pkg::PH_FETCH: begin
                if (run_ff && is_logic && tp) begin
                    nxt_ph = sao_pkg::PH_EXEC;
                end else if (run_ff && is_xchg && t24) begin
                    nxt_ph = sao_pkg::PH_XFER; // RQ5
                end else if (run_ff && is_shift && at(bt_ff, sao_pkg::BT_T9)) begin
                    nxt_ph = sao_pkg::PH_COUNT; // RQ14 RQ22
                end
            end
            sao_pkg::PH_EXEC: if (tp) nxt_ph = sao_pkg::PH_FETCH; // RQ4
            sao_pkg::PH_XFER: if (tp) nxt_ph = sao_pkg::PH_FETCH;
            sao_pkg::PH_COUNT: if (tp && skip_ff) nxt_ph = sao_pkg::PH_NEXT; // RQ19
            sao_pkg::PH_NEXT: if (tp) nxt_ph = sao_pkg::PH_FETCH; // RQ21
        endcase
    end

    localparam logic [0:23] RST_CLEAR = sao_pkg::RST_WORD;

    // Word registers
    always_comb begin
        nxt_acc = acc_ff;
        nxt_ext = ext_ff;
        nxt_idx = idx_ff;
        nxt_op = op_ff;
        nxt_addr = addr_ff;
        unique case (ph_ff)
            sao_pkg::PH_FETCH: begin
                if (run_ff && dbt) begin
                    nxt_op = {sum, op_ff[0:22]}; // RQ13
                    nxt_idx = {xb, idx_ff[0:22]};
                end
                if (run_ff && is_logic && tp) begin
                    nxt_op = mem_ff;
                end
                if (run_ff && at(bt_ff, sao_pkg::BT_T10)) begin
                    nxt_addr = '0; // RQ14
                end
                if (run_ff && at(bt_ff, sao_pkg::BT_T9)) begin
                    nxt_addr = ld; // RQ14
                end
            end
            sao_pkg::PH_EXEC: begin
                if (dbt) begin
                    nxt_acc = {lres, acc_ff[0:22]}; // RQ1 RQ2 RQ3
                    nxt_op = {cb, op_ff[0:22]};
                end
            end
            sao_pkg::PH_XFER: begin
                if (dbt) begin
                    nxt_acc = {a_new, acc_ff[0:22]}; // RQ6
                    nxt_ext = {e_new, ext_ff[0:22]}; // RQ23
                    nxt_idx = {x_new, idx_ff[0:22]}; // RQ23
                end
                if (short_xchg) begin
                    nxt_op = RST_CLEAR; // RQ8
                end
            end
            sao_pkg::PH_COUNT: begin
                if (at(bt_ff, sao_pkg::BT_T23) && !single_ff && !mhold_ff && !cnt_zero) begin
                    nxt_addr[9:13] = cnt - 5'h01; // RQ15 RQ18
                end
                if (tp && active_ff && is_rsh && !single_ff) begin
                    nxt_acc = {fill2, acc_ff[0:21]}; // RQ16
                    nxt_ext = {ah1_ff, ah2_ff, ext_ff[0:21]}; // RQ16
                end else if (tp && active_ff && is_rsh) begin
                    nxt_acc = {fill1, acc_ff[0:22]}; // RQ20
                    nxt_ext = {ah2_ff, ext_ff[0:22]}; // RQ20
                end else if (tp && active_ff && !single_ff) begin
                    nxt_acc = {acc_ff[2:23], ext_ff[0:1]}; // RQ22
                    nxt_ext = {ext_ff[2:23], lfill};
                end else if (tp && active_ff) begin
                    nxt_acc = {acc_ff[1:23], ext_ff[0]};
                    nxt_ext = {ext_ff[1:23], lfill[0]};
                end
            end
            sao_pkg::PH_NEXT: begin
                if (at(bt_ff, sao_pkg::BT_T9)) begin
                    nxt_addr = {1'b0, pc_ff}; // RQ21
                end
                if (tp) begin
                    nxt_op = mem_ff; // RQ21
                end
            end
        endcase
        if (idle && wr_hit(req_ff, sao_pkg::A_INSTR)) nxt_op = hwdata[23:0];
        if (idle && wr_hit(req_ff, sao_pkg::A_ACC)) nxt_acc = hwdata[23:0];
        if (idle && wr_hit(req_ff, sao_pkg::A_EXT)) nxt_ext = hwdata[23:0];
        if (idle && wr_hit(req_ff, sao_pkg::A_IDX)) nxt_idx = hwdata[23:0];
    end

    // Flag set and clear terms
    wire logic ix_set = (fetch_run && t24 && is_shift && op_ff[sao_pkg::F_INDEX_TAG])
        || (short_xchg && !x_keep); // RQ9 RQ10
    wire logic ix_clr = (fetch_run && at(bt_ff, sao_pkg::BT_T16))
        || (tp && !mhold_ff); // RQ10
    wire logic skip_set = ph_count && t0 && ((single_ff && active_ff)
        || (cnt_zero && !odd && !single_ff)); // RQ19 RQ20
    wire logic single_set = ph_count && tp && !single_ff && !skip_ff && cnt_zero && odd;

    always_ff @(posedge clock) begin
        if (reset) begin
            bt_ff <= sao_pkg::BT_T24;
            ph_ff <= sao_pkg::PH_FETCH;
            {acc_ff, ext_ff, idx_ff, op_ff, mem_ff} <= {5{sao_pkg::RST_WORD}};
            addr_ff <= '0;
            pc_ff <= sao_pkg::RST_PC;
            opc_ff <= 6'h00;
        end else begin
            bt_ff <= tp ? sao_pkg::BT_T24 : t0 ? sao_pkg::BT_TP : bt_ff - 5'h01;
            ph_ff <= nxt_ph;
            if (fetch_run && t24) opc_ff <= op_ff[3:8];
            {acc_ff, ext_ff, idx_ff, op_ff, addr_ff} <= {nxt_acc, nxt_ext, nxt_idx,
                nxt_op, nxt_addr};
            if (idle && wr_hit(req_ff, sao_pkg::A_MEM)) mem_ff <= hwdata[23:0];
            if (idle && wr_hit(req_ff, sao_pkg::A_PC)) begin
                pc_ff <= hwdata[13:0];
            end else if (ph_next && t24 && inc_ff) begin
                pc_ff <= pc_ff + 14'h0001; // RQ21
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            {run_ff, pend_ff, seen_ff, ix_ff, carry_ff, shmode_ff, fill_ff} <= '0;
            {single_ff, skip_ff, inc_ff, active_ff, mhold_ff, mem_pulse_ff} <= '0;
            {ah1_ff, ah2_ff, eh1_ff, eh2_ff} <= '0;
        end else begin
            pend_ff <= (pend_ff && !start) || (idle && wr_hit(req_ff, sao_pkg::A_INSTR));
            run_ff <= start || (run_ff && !(tp && !ph_count && !nxt_ph[0]
                && !(ph_fetch && !is_xchg && is_logic) && !(ph_fetch && is_shift)));
            if (idle && wr_hit(req_ff, sao_pkg::A_CTRL)) mhold_ff <= hwdata[0];
            ix_ff <= ix_set || (ix_ff && !ix_clr);
            carry_ff <= fetch_run && dbt && ix_ff && cout; // RQ12
            seen_ff <= ph_xfer && dbt && !t0 && (seen_ff || ab); // RQ7
            if (fetch_run && is_shift && at(bt_ff, sao_pkg::BT_T9)) begin
                shmode_ff <= ld[sao_pkg::F_CYCLE]; // RQ11 RQ22
                fill_ff <= ld[sao_pkg::F_FILL]; // RQ17
            end
            active_ff <= ph_count && (t24 ? (!cnt_zero || single_ff) : active_ff);
            if (ph_count && t24) begin
                {ah1_ff, ah2_ff, eh1_ff, eh2_ff} <= {acc_ff[22:23], ext_ff[22:23]}; // RQ16
            end
            single_ff <= single_set || (single_ff && !(ph_next && tp)); // RQ20
            skip_ff <= skip_set || (skip_ff && !(ph_next && tp)); // RQ19
            inc_ff <= (ph_count && tp && skip_ff) || (inc_ff && !(ph_next && tp)); // RQ21
            mem_pulse_ff <= at(bt_ff, sao_pkg::BT_T8) && !ph_count; // RQ15
        end
    end

    // Bus slave: zero wait states, always OKAY
    always_ff @(posedge clock) begin
        if (reset) begin
            req_ff <= '0;
            hrdata_ff <= 32'h00000000;
        end else begin
            req_ff <= nxt_req;
            if (nxt_req.valid && !hwrite) hrdata_ff <= rd_data;
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign mem_pulse = mem_pulse_ff;

    default clocking cb_main @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_shift_t10;
        fetch_run && is_shift && at(bt_ff, sao_pkg::BT_T10);
    endsequence
    sequence s_load_count;
        addr_ff == 15'h0000 ##1 ph_ff == sao_pkg::PH_COUNT;
    endsequence

    and_result_a: assert property ((ph_ff == sao_pkg::PH_EXEC && dbt && is_and) |=> // RQ1
        acc_ff[0] == ($past(acc_ff[23]) && $past(op_ff[23])))
        else $error("AND result bit wrong");
    or_result_a: assert property ((ph_ff == sao_pkg::PH_EXEC && dbt && is_or) |=> // RQ2
        acc_ff[0] == ($past(acc_ff[23]) || $past(op_ff[23])))
        else $error("OR result bit wrong");
    xor_result_a: assert property ((ph_ff == sao_pkg::PH_EXEC && dbt && is_xor) |=> // RQ3
        acc_ff[0] == ($past(acc_ff[23]) ^ $past(op_ff[23])))
        else $error("XOR result bit wrong");
    exec_return_a: assert property ((ph_ff == sao_pkg::PH_EXEC && tp) |=> ph_fetch) // RQ4
        else $error("Execute did not return to fetch");
    xchg_enter_a: assert property ((fetch_run && is_xchg && t24) |=> ph_xfer [*8]) // RQ5
        else $error("Register change phase not entered");
    comp_clear_a: assert property ((ph_xfer && t0) |=> !seen_ff) // RQ7
        else $error("Complement flag not cleared at T0");
    carry_off_a: assert property (!ix_ff |=> !carry_ff) // RQ12
        else $error("Carry active without index flag");
    addr_load_a: assert property (s_shift_t10 |=> s_load_count) // RQ14
        else $error("Address clear or count entry wrong");
    mem_quiet_a: assert property ((at(bt_ff, sao_pkg::BT_T8) && ph_count) |=> !mem_pulse) // RQ15
        else $error("Memory pulse while counting");
    skip_exit_a: assert property ((ph_count && tp && skip_ff) |=> ph_next ##26 ph_fetch) // RQ19
        else $error("Skip did not pass through next phase");
    single_once_a: assert property ($rose(single_ff) |-> ##[1:27] skip_ff) // RQ20
        else $error("Single shift not followed by skip");
    adder_pass_a: assert property ((fetch_run && dbt && !ix_ff) |-> sum == cb) // RQ13
        else $error("Adder altered operand without indexing");
    short_stop_a: assert property (short_xchg |=> op_ff == sao_pkg::RST_WORD) // RQ8
        else $error("Short exchange did not clear operand");
    right_hold_a: assert property ((ph_count && tp && active_ff && is_rsh && !single_ff) // RQ16
        |=> ext_ff[0:1] == $past(acc_ff[22:23]))
        else $error("Right shift lost low accumulator bits");
    pc_step_a: assert property ((ph_next && t24 && inc_ff) // RQ21
        |=> pc_ff == $past(pc_ff) + 14'h0001)
        else $error("Program counter not stepped");
endmodule : sao_serial_acc

// ===== testbench/sao_mem_model.sv
/*
 * Memory-side partner: counts the block's memory pulses, flags wide ones.
 * Assumes the block's clock and its synchronous active-high reset.
 */
`timescale 1ns/1ps
module sao_mem_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Memory timing from the block
    input wire logic mem_pulse,
    // Observation
    output logic [15:0] pulse_cnt_ff,
    output logic wide_ff
);
    logic prev_ff;

    // A core memory cycle is started by one pulse; a held pulse would restart it
    always_ff @(posedge clock) begin
        if (reset) begin
            prev_ff <= 1'b0;
            pulse_cnt_ff <= 16'h0000;
            wide_ff <= 1'b0;
        end else begin
            prev_ff <= mem_pulse;
            pulse_cnt_ff <= pulse_cnt_ff + {15'h0000, mem_pulse};
            wide_ff <= wide_ff | (mem_pulse & prev_ff);
        end
    end
endmodule : sao_mem_model

// ===== testbench/sao_serial_acc_tb.sv
/*
 * Self-checking bench: AHB-Lite master, read notes queue, monitor compares.
 * Assumes a zero-wait single slave whose hreadyout is the bus ready.
 */
`timescale 1ns/1ps
module sao_serial_acc_tb;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] exp;
        logic [31:0] mask;
    } sao_note_s;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = sao_pkg::WORD_SIZE;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic mem_pulse;
    logic [15:0] pulse_cnt;
    logic wide;
    logic rd_chk = 1'b0;
    sao_note_s note_q[$];
    sao_note_s cur;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    integer seed = 32'h3DB2F7BF;
    logic [5:0] lop[3] = '{sao_pkg::OPC_AND, sao_pkg::OPC_OR, sao_pkg::OPC_XOR};
    logic [9:0] rc_bits[10] = '{10'h008, 10'h080, 10'h001, 10'h200, 10'h004,
                                10'h020, 10'h002, 10'h010, 10'h100, 10'h140};
    int nlist[4] = '{0, 1, 2, 5};
    logic [23:0] a, b, x, y;
    logic [47:0] ab;
    logic [31:0] q, p0, c0;
    int sh, e0;

    always #25 clock = ~clock;
    always @(posedge clock) cyc++;

    sao_serial_acc u_sao_serial_acc (.clock(clock), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .mem_pulse(mem_pulse));
    sao_mem_model u_sao_mem_model (.clock(clock), .reset(reset), .mem_pulse(mem_pulse),
        .pulse_cnt_ff(pulse_cnt), .wide_ff(wide));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clock);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                err_total++;
                tally_and_finish();
            end
            @(posedge clock);
        end
    endtask : wait_rdy

    task automatic bus_wr(input logic [7:0] ad, input logic [31:0] d);
        hsel <= 1'b1;
        hwrite <= 1'b1;
        haddr <= {24'h000000, ad};
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask : bus_wr

    // Read data is taken at the edge that ends the data phase
    task automatic bus_rd(input logic [7:0] ad, input logic chk, input logic [31:0] e,
                          input logic [31:0] m, output logic [31:0] r);
        hsel <= 1'b1;
        hwrite <= 1'b0;
        haddr <= {24'h000000, ad};
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        if (chk) begin
            note_q.push_back('{ad, e, m});
            rd_chk <= 1'b1;
        end
        wait_rdy();
        r = hrdata;
        rd_chk <= 1'b0;
    endtask : bus_rd

    task automatic rd_expect(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] r;
        bus_rd(ad, 1'b1, e, m, r);
    endtask : rd_expect

    // Busy covers a pending instruction too, so polling may start at once
    task automatic wait_idle();
        logic [31:0] s;
        int n;
        n = 0;
        s = 32'h00000008;
        while (s[3] !== 1'b0) begin
            bus_rd(sao_pkg::A_STATUS, 1'b0, 32'h00000000, 32'h00000000, s);
            n++;
            if (n > 2000) begin
                err_total++;
                tally_and_finish();
            end
        end
    endtask : wait_idle

    function automatic logic [31:0] ins(input logic [5:0] op, input logic [14:0] low);
        ins = {11'h000, op, low};
    endfunction : ins

    always @(posedge clock) begin
        if (rd_chk === 1'b1 && hreadyout === 1'b1) begin
            cur = note_q.pop_front();
            check($sformatf("reg %h", cur.addr), hrdata & cur.mask, cur.exp & cur.mask);
        end
    end

    initial begin
        #5000000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 10; i++) begin
            rd_expect((i == 9) ? 8'h40 : 8'(i * 4), 32'h00000000, 32'hFFFFFFFF);
        end
        q = {16'h0000, pulse_cnt};
        repeat (260) @(posedge clock);
        check("idle pulses", {16'h0000, pulse_cnt} - q, 32'h0000000A);
        bus_wr(sao_pkg::A_CTRL, 32'h00000001);
        rd_expect(sao_pkg::A_CTRL, 32'h00000001, 32'h00000001);
        bus_wr(sao_pkg::A_CTRL, 32'h00000000);
        for (int i = 0; i < 3; i++) begin
            a = 24'($random(seed));
            b = 24'($random(seed));
            bus_wr(sao_pkg::A_ACC, {8'h00, a});
            bus_wr(sao_pkg::A_MEM, {8'h00, b});
            bus_wr(sao_pkg::A_INSTR, ins(lop[i], 15'h0000));
            // Refused while busy, so the result must not see it
            bus_wr(sao_pkg::A_ACC, {8'h00, ~a});
            wait_idle();
            y = (i == 0) ? (a & b) : (i == 1) ? (a | b) : (a ^ b);
            rd_expect(sao_pkg::A_ACC, {8'h00, y}, 32'h00FFFFFF);
            rd_expect(sao_pkg::A_STATUS, 32'h00000000, 32'h0000000F);
        end
        for (int i = 0; i < 10; i++) begin
            a = 24'($random(seed));
            b = 24'($random(seed));
            x = 24'($random(seed));
            bus_wr(sao_pkg::A_ACC, {8'h00, a});
            bus_wr(sao_pkg::A_EXT, {8'h00, b});
            bus_wr(sao_pkg::A_IDX, {8'h00, x});
            bus_wr(sao_pkg::A_INSTR, ins(sao_pkg::OPC_XCHG, {5'h00, rc_bits[i]}));
            wait_idle();
            case (i)
                0, 7: y = b;
                1, 5: y = x;
                2, 6: y = 24'h000000;
                3: y = -a;
                4, 8: y = a;
                default: y = {{15{a[8]}}, a[8:0]};
            endcase
            rd_expect((i < 4) ? sao_pkg::A_ACC : (i < 7) ? sao_pkg::A_EXT : sao_pkg::A_IDX,
                      {8'h00, y}, 32'h00FFFFFF);
        end
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 4; k++) begin
                a = 24'($random(seed));
                b = 24'($random(seed));
                bus_wr(sao_pkg::A_ACC, {8'h00, a});
                bus_wr(sao_pkg::A_EXT, {8'h00, b});
                bus_wr(sao_pkg::A_MEM, 32'h00000000);
                bus_rd(sao_pkg::A_PC, 1'b0, 32'h00000000, 32'h00000000, p0);
                sh = nlist[k] + ((m == 1) ? 16 : (m == 2) ? 32 : 0);
                c0 = {16'h0000, pulse_cnt};
                e0 = cyc;
                bus_wr(sao_pkg::A_INSTR, ins((m == 3) ? sao_pkg::OPC_LSH : sao_pkg::OPC_RSH,
                       {m == 2, m == 1, 3'(nlist[k] / 2), nlist[k][0], 9'h000}));
                wait_idle();
                ab = {a, b};
                if (m == 1) begin
                    ab = (ab >> sh) | (ab << (48 - sh));
                end else if (m == 2) begin
                    ab = ab >> sh;
                end else if (m == 3) begin
                    ab = ab << sh;
                end else begin
                    ab = 48'($signed(ab) >>> sh);
                end
                rd_expect(sao_pkg::A_ACC, {8'h00, ab[47:24]}, 32'h00FFFFFF);
                rd_expect(sao_pkg::A_EXT, {8'h00, ab[23:0]}, 32'h00FFFFFF);
                if (m == 2) begin
                    check("count pulses", {31'h0, ({16'h0000, pulse_cnt} - c0 + 12) <=
                          32'((cyc - e0) / 26)}, 32'h00000001);
                end
                bus_rd(sao_pkg::A_PC, 1'b0, 32'h00000000, 32'h00000000, q);
                check("pc step", q & 32'h00003FFF, (p0 + 1) & 32'h00003FFF);
            end
        end
        check("pulse width", {31'h0, wide}, 32'h00000000);
        tally_and_finish();
    end
endmodule : sao_serial_acc_tb
